// file: rtl/hrm_pkg.sv
// Constants, types and decode helpers for the host register map block.
// Assumes a single 25 MHz clock and a synchronous, active-high reset.
// Summary of operation
// - Loader puts low byte of a word before its high byte in address.
// - Loader ignores words 0 and 4 to 6; never reads words 7 upward.
// - With loading enabled, words 1 to 3 fill host address at 0x110.
// - Byte space 0x000 to 0x7ff is decoded and open to host access.
// - Areas: control 0x000, host unit 0x100, queues, timer, clock.
// - Indirect data window and its control sit at 0x026 to 0x031.
// - PHY management registers sit at 0x044 to 0x06b.
// - Accesses are 8 or 16 bits wide; a register spans two bytes.
// - Global controls one and seven reset to 0x3450 and 0x0827.
// - PHY basic control and status reset to 0x3120 and 0x7808.
// - Advertisement resets to 0x05e1, partner ability to 0x0001.
// - Sleep time resets to 0x008e; power registers reset to zero.
// - Port control four 0x00ff, port status 0x8000, diag 0x0400.
// - Identity register at 0x000 holds fixed upper identity bits.
// - Station word three resets to 0xffff, words one, two to zero.
// - Loader strap sampled after reset; seven words are read.
`default_nettype none
package hrm_pkg;
   // Byte offsets of the documented registers.
   localparam logic [10:0] OFF_CHIP_ID = 11'h000;
   localparam logic [10:0] OFF_GCTL1 = 11'h002;
   localparam logic [10:0] OFF_GCTL7 = 11'h00e;
   localparam logic [10:0] OFF_STA1 = 11'h010;
   localparam logic [10:0] OFF_STA2 = 11'h012;
   localparam logic [10:0] OFF_STA3 = 11'h014;
   localparam logic [10:0] OFF_IND1 = 11'h026;
   localparam logic [10:0] OFF_IND4 = 11'h02c;
   localparam logic [10:0] OFF_IND5 = 11'h02e;
   localparam logic [10:0] OFF_INDCTL = 11'h030;
   localparam logic [10:0] OFF_PMCTL = 11'h032;
   localparam logic [10:0] OFF_POWER_EVENT_ENABLE = 11'h034;
   localparam logic [10:0] OFF_SLEEP = 11'h036;
   localparam logic [10:0] OFF_CTPD = 11'h038;
   localparam logic [10:0] OFF_PHYCTL = 11'h04c;
   localparam logic [10:0] OFF_PHYSTS = 11'h04e;
   localparam logic [10:0] OFF_PHYIDL = 11'h050;
   localparam logic [10:0] OFF_PHYIDH = 11'h052;
   localparam logic [10:0] OFF_ANADV = 11'h054;
   localparam logic [10:0] OFF_ANLP = 11'h056;
   localparam logic [10:0] OFF_PHYSPC = 11'h066;
   localparam logic [10:0] OFF_PCTL1 = 11'h06c;
   localparam logic [10:0] OFF_DIAG = 11'h07c;
   localparam logic [10:0] OFF_PCTL4 = 11'h07e;
   localparam logic [10:0] OFF_PSTS = 11'h080;
   localparam logic [10:0] OFF_HOSTMAC = 11'h110;
   // Area boundaries.
   localparam logic [10:0] OFF_AREA_HOST = 11'h100;
   localparam logic [10:0] OFF_AREA_QUEUE = 11'h170;
   localparam logic [10:0] OFF_AREA_TRIG = 11'h200;
   localparam logic [10:0] OFF_AREA_CLOCK = 11'h600;
   localparam logic [10:0] OFF_TOP = 11'h7ff;
   // Reset values.
   localparam logic [15:0] RST_GCTL1 = 16'h3450;
   localparam logic [15:0] RST_GCTL7 = 16'h0827;
   localparam logic [15:0] RST_STA3 = 16'hffff;
   localparam logic [15:0] RST_SLEEP = 16'h008e;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_PHYCTL = 16'h3120;
   localparam logic [15:0] RST_PHYSTS = 16'h7808;
   localparam logic [15:0] RST_ANADV = 16'h05e1;
   localparam logic [15:0] RST_ANLP = 16'h0001;
   localparam logic [15:0] RST_PHYSPC = 16'h0004;
   localparam logic [15:0] RST_DIAG = 16'h0400;
   localparam logic [15:0] RST_PCTL4 = 16'h00ff;
   localparam logic [15:0] RST_PSTS = 16'h8000;
   // Serial memory words.
   localparam logic [5:0] EE_MAC_FIRST = 6'h01;
   localparam logic [5:0] EE_MAC_LAST = 6'h03;
   localparam int unsigned EE_WORDS = 7;
   // Cycles that the pin synchronisers need before straps are valid.
   localparam logic [2:0] SETTLE_CYCLES = 3'h4;
   // Idle level of the filtered pins.
   localparam logic [21:0] PIN_IDLE = 22'h380000;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic cmd;
      logic bus16;
      logic ee_strap;
      logic [15:0] sd;
   } hrm_pins_t;

   typedef struct packed {
      logic req;
      logic [5:0] addr;
   } hrm_ee_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } hrm_ee_rsp_t;

   typedef enum logic [1:0] {
      LD_SETTLE = 2'b00,
      LD_READ = 2'b01,
      LD_DONE = 2'b10
   } hrm_ld_state_t;

   function automatic logic [9:0] hrm_idx(input logic [10:0] off);
      return off[10:1];
   endfunction

   // Reset value of a control-area word.
   function automatic logic [15:0] hrm_rst(input logic [9:0] i);
      logic [15:0] v;
      v = RST_ZERO;
      if (i == hrm_idx(OFF_GCTL1)) v = RST_GCTL1;
      else if (i == hrm_idx(OFF_GCTL7)) v = RST_GCTL7;
      else if (i == hrm_idx(OFF_STA3)) v = RST_STA3;
      else if (i == hrm_idx(OFF_SLEEP)) v = RST_SLEEP;
      else if (i == hrm_idx(OFF_PHYCTL)) v = RST_PHYCTL;
      else if (i == hrm_idx(OFF_PHYSTS)) v = RST_PHYSTS;
      else if (i == hrm_idx(OFF_ANADV)) v = RST_ANADV;
      else if (i == hrm_idx(OFF_ANLP)) v = RST_ANLP;
      else if (i == hrm_idx(OFF_PHYSPC)) v = RST_PHYSPC;
      else if (i == hrm_idx(OFF_DIAG)) v = RST_DIAG;
      else if (i == hrm_idx(OFF_PCTL4)) v = RST_PCTL4;
      else if (i == hrm_idx(OFF_PSTS)) v = RST_PSTS;
      return v;
   endfunction

   // Bits of a control-area word that host writes may change.
   function automatic logic [15:0] hrm_wmask(input logic [9:0] i);
      logic [15:0] m;
      m = 16'h0000;
      if (i == hrm_idx(OFF_CHIP_ID)) m = 16'h0001;
      else if (i == hrm_idx(OFF_GCTL1) || i == hrm_idx(OFF_GCTL7))
         m = 16'hffff;
      else if (i >= hrm_idx(OFF_STA1) && i <= hrm_idx(OFF_STA3))
         m = 16'hffff;
      else if (i == hrm_idx(OFF_IND1) || i == hrm_idx(OFF_IND4))
         m = 16'hffff;
      else if (i >= hrm_idx(OFF_IND5) && i <= hrm_idx(OFF_CTPD))
         m = 16'hffff;
      else if (i == hrm_idx(OFF_PHYCTL) || i == hrm_idx(OFF_ANADV))
         m = 16'hffff;
      else if (i == hrm_idx(OFF_PHYSPC) || i == hrm_idx(OFF_PCTL1))
         m = 16'hffff;
      else if (i == hrm_idx(OFF_DIAG) || i == hrm_idx(OFF_PCTL4))
         m = 16'hffff;
      return m;
   endfunction

   // Control-area words that exist; all others read as zero.
   function automatic logic hrm_mapped(input logic [9:0] i);
      return (hrm_wmask(i) != 16'h0000) || i == hrm_idx(OFF_PHYSTS)
         || i == hrm_idx(OFF_PHYIDL) || i == hrm_idx(OFF_PHYIDH)
         || i == hrm_idx(OFF_ANLP) || i == hrm_idx(OFF_PSTS);
   endfunction
endpackage
`default_nettype wire

// file: rtl/hrm_regbank.sv
// Host register bank with command/data host bus and start-up loader.
// Assumes asynchronous host pins and a same-clock serial memory reader.
`default_nettype none
module hrm_regbank import hrm_pkg::*; #(
   parameter logic [15:1] CHIP_ID = 15'h2d28,  // Arbitrary value.
   parameter logic [15:0] PHY_ID_LOW = 16'h0b5c,  // Arbitrary value.
   parameter logic [15:0] PHY_ID_HIGH = 16'h00a7,  // Arbitrary value.
   parameter int unsigned LOAD_WORDS = EE_WORDS
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Host bus pins and straps.
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cmd,
   input wire logic [15:0] sd_in,
   output logic [15:0] sd_out,
   output logic sd_oe_n,
   input wire logic bus16_strap,
   input wire logic ee_strap,
   // Serial memory word reader.
   output hrm_ee_req_t ee_req,
   input wire hrm_ee_rsp_t ee_rsp,
   // Status.
   output logic ee_load_done,
   output logic bus16_mode
);
   localparam int unsigned CTL_WORDS = 128;
   localparam int unsigned UP_WORDS = 896;

   if (LOAD_WORDS < 4 || LOAD_WORDS > EE_WORDS) begin : g_check
      $error("LOAD_WORDS must lie between 4 and EE_WORDS");
   end

   hrm_pins_t raw;
   hrm_pins_t s1, s2, s3, lvl, prev;
   logic [15:0] ctl_q [0:CTL_WORDS-1];
   logic [15:0] up_q [0:UP_WORDS-1];
   logic [10:0] badr;
   logic [3:0] be;
   logic aphase;
   logic [2:0] settle;
   hrm_ld_state_t ld_state;
   logic [5:0] ld_addr;
   logic [15:0] rdata;
   logic wr_ev, rd_ev, cmd_wr, data_wr, ld_store;
   logic [9:0] widx;
   logic [1:0] lanes;
   logic [15:0] wdata, rd_word;

   assign raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, cmd: cmd,
      bus16: bus16_strap, ee_strap: ee_strap, sd: sd_in};

   // Three-stage pin synchronisers; a change counts once stages agree.
   always_ff @(posedge clk_sys) begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lvl <= PIN_IDLE;
         prev <= PIN_IDLE;
      end else begin
         lvl <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
         prev <= lvl;
      end
   end

   // Falling strobes with chip select; address first, then data.
   assign wr_ev = prev.wr_n & ~lvl.wr_n & ~lvl.cs_n;
   assign rd_ev = prev.rd_n & ~lvl.rd_n & ~lvl.cs_n;
   assign cmd_wr = wr_ev & lvl.cmd;
   assign data_wr = wr_ev & ~lvl.cmd;

   // Word index and byte lanes of the current access.
   always_comb begin
      if (bus16_mode) begin
         if (be[1:0] != 2'b00 || be[3:2] == 2'b00) begin
            widx = {badr[10:2], 1'b0};
            lanes = be[1:0];
         end else begin
            widx = {badr[10:2], 1'b1};
            lanes = be[3:2];
         end
         wdata = lvl.sd;
      end else begin
         widx = badr[10:1];
         lanes = badr[0] ? 2'b10 : 2'b01;
         wdata = {lvl.sd[7:0], lvl.sd[7:0]};
      end
   end

   // Address capture: one cycle in 16-bit mode, two in 8-bit mode.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         badr <= 11'h000;
         be <= 4'h0;
         aphase <= 1'b0;
      end else if (cmd_wr) begin
         if (bus16_mode) begin
            badr <= {lvl.sd[10:2], 2'b00};
            be <= lvl.sd[15:12];
         end else if (!aphase) begin
            badr[7:0] <= lvl.sd[7:0];
            aphase <= 1'b1;
         end else begin
            badr[10:8] <= lvl.sd[2:0];
            aphase <= 1'b0;
         end
      end
   end

   // Control area 0x000 to 0x0ff with reset values and write masks.
   for (genvar i = 0; i < CTL_WORDS; i++) begin : g_ctl
      localparam logic [9:0] IDX = 10'(i);
      localparam logic [15:0] MASK = hrm_wmask(IDX);
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            if (IDX == hrm_idx(OFF_CHIP_ID))
               ctl_q[i] <= {CHIP_ID, 1'b0};
            else if (IDX == hrm_idx(OFF_PHYIDL))
               ctl_q[i] <= PHY_ID_LOW;
            else if (IDX == hrm_idx(OFF_PHYIDH))
               ctl_q[i] <= PHY_ID_HIGH;
            else
               ctl_q[i] <= hrm_rst(IDX);
         end else if (data_wr && widx == IDX) begin
            // Only mapped writable bits change; reserved ones hold.
            for (int b = 0; b < 16; b++) begin
               if (MASK[b] && lanes[b / 8])
                  ctl_q[i][b] <= wdata[b];
            end
         end
      end
   end

   // Upper areas 0x100 to 0x7ff; the loader has priority.
   always_ff @(posedge clk_sys) begin
      if (ld_store) begin
         up_q[hrm_idx(OFF_HOSTMAC) - 10'(CTL_WORDS)
            + 10'(ld_addr - EE_MAC_FIRST)] <= ee_rsp.data;
      end else if (data_wr && widx >= 10'(CTL_WORDS)) begin
         if (lanes[0])
            up_q[widx - 10'(CTL_WORDS)][7:0] <= wdata[7:0];
         if (lanes[1])
            up_q[widx - 10'(CTL_WORDS)][15:8] <= wdata[15:8];
      end
   end

   // Read word: indirect window, PHY block and rest of the map.
   always_comb begin
      if (widx >= 10'(CTL_WORDS))
         rd_word = up_q[widx - 10'(CTL_WORDS)];
      else if (hrm_mapped(widx))
         rd_word = ctl_q[widx[6:0]];
      else
         rd_word = 16'h0000;
   end

   // Read data latched on the read strobe and held until the next one.
   always_ff @(posedge clk_sys) begin
      if (rst)
         rdata <= 16'h0000;
      else if (rd_ev) begin
         if (lvl.cmd)
            rdata <= bus16_mode ? {be, 1'b0, badr[10:2], 2'b00} : 16'h0000;
         else if (bus16_mode) begin
            rdata <= rd_word;
         end else
            rdata <= {8'h00, badr[0] ? rd_word[15:8] : rd_word[7:0]};
      end
   end

   assign sd_out = rdata;
   assign sd_oe_n = lvl.rd_n | lvl.cs_n | prev.rd_n;

   // Strap capture after release, then the start-up word reader.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ld_state <= LD_SETTLE;
         settle <= 3'h0;
         ld_addr <= 6'h00;
         bus16_mode <= 1'b0;
      end else begin
         case (ld_state)
            LD_SETTLE: begin
               settle <= settle + 3'h1;
               if (settle == SETTLE_CYCLES) begin
                  bus16_mode <= lvl.bus16;
                  ld_state <= lvl.ee_strap ? LD_READ : LD_DONE;
               end
            end
            LD_READ: begin
               if (ee_rsp.valid) begin
                  if (ld_addr == 6'(LOAD_WORDS - 1))
                     ld_state <= LD_DONE;
                  else
                     ld_addr <= ld_addr + 6'h01;
               end
            end
            LD_DONE: begin
               ld_state <= LD_DONE;
            end
            default: begin
               ld_state <= LD_DONE;
            end
         endcase
      end
   end

   // Only words 1 to 3 are kept; low byte is the earlier one.
   assign ld_store = ld_state == LD_READ && ee_rsp.valid
      && ld_addr >= EE_MAC_FIRST && ld_addr <= EE_MAC_LAST;
   assign ee_req = '{req: ld_state == LD_READ, addr: ld_addr};
   assign ee_load_done = ld_state == LD_DONE;

   // Checks.
   localparam logic [9:0] MAC0 = 10'h008;
   sequence s_mac_word(int n);
      ee_req.req && ee_rsp.valid && ee_req.addr == 6'(n);
   endsequence

   a_ee_low_first: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_mac_word(1) |=> up_q[MAC0][7:0] == $past(ee_rsp.data[7:0])
         && up_q[MAC0][15:8] == $past(ee_rsp.data[15:8]))
      else $error("host address word one loaded in wrong byte order");
   a_ee_third_word: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_mac_word(3) |=> up_q[MAC0 + 10'h002] == $past(ee_rsp.data))
      else $error("host address word three not loaded");
   a_ee_skip_rsvd: assert property (
      @(posedge clk_sys) disable iff (rst)
      (s_mac_word(0) or s_mac_word(4) or s_mac_word(5) or s_mac_word(6))
         |-> !ld_store)
      else $error("reserved memory word altered host address");
   a_ee_mac_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      (s_mac_word(4) or s_mac_word(5) or s_mac_word(6)) |=>
         $stable(up_q[MAC0]) && $stable(up_q[MAC0 + 10'h001])
         && $stable(up_q[MAC0 + 10'h002]))
      else $error("host address changed after word three");
   a_ee_seven_words: assert property (
      @(posedge clk_sys) disable iff (rst)
      ee_req.req |-> ee_req.addr <= 6'h06)
      else $error("loader read beyond word six");
   a_rst_globals: assert property (
      @(posedge clk_sys) $fell(rst) |-> ctl_q[1] == RST_GCTL1
         && ctl_q[7] == RST_GCTL7)
      else $error("global controls wrong after reset");
   a_rst_phy_basic: assert property (
      @(posedge clk_sys) $fell(rst) |-> ctl_q[38] == RST_PHYCTL
         && ctl_q[39] == RST_PHYSTS)
      else $error("PHY basic registers wrong after reset");
   a_rst_autoneg: assert property (
      @(posedge clk_sys) $fell(rst) |-> ctl_q[42] == RST_ANADV
         && ctl_q[43] == RST_ANLP)
      else $error("autonegotiation registers wrong after reset");
   a_rst_power: assert property (
      @(posedge clk_sys) $fell(rst) |-> ctl_q[27] == RST_SLEEP
         && ctl_q[25] == 16'h0000 && ctl_q[26] == 16'h0000
         && ctl_q[28] == 16'h0000)
      else $error("power registers wrong after reset");
   a_rst_port: assert property (
      @(posedge clk_sys) $fell(rst) |-> ctl_q[63] == RST_PCTL4
         && ctl_q[64] == RST_PSTS && ctl_q[62] == RST_DIAG)
      else $error("port registers wrong after reset");
   a_rst_station: assert property (
      @(posedge clk_sys) $fell(rst) |-> ctl_q[10] == RST_STA3)
      else $error("station word three wrong after reset");
   a_id_fixed: assert property (
      @(posedge clk_sys) disable iff (rst) ctl_q[0][15:1] == CHIP_ID)
      else $error("identity bits changed");
   a_rsvd_write: assert property (
      @(posedge clk_sys) disable iff (rst)
      data_wr && widx == 10'h002 |=> ctl_q[2] == 16'h0000)
      else $error("reserved word took a write");
   a_write_lands: assert property (
      @(posedge clk_sys) disable iff (rst)
      data_wr && bus16_mode && widx == 10'h001 && lanes == 2'b11 |=>
         ctl_q[1] == $past(wdata))
      else $error("host write to global control one lost");
endmodule
`default_nettype wire

// file: tb/hrm_ee_model.sv
// Serial memory word reader model facing the start-up loader.
// Assumes the loader holds req and addr steady until valid is seen.
`default_nettype none
module hrm_ee_model import hrm_pkg::*; (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Word reader handshake.
   input wire hrm_ee_req_t ee_req,
   output hrm_ee_rsp_t ee_rsp,
   // Stored station address and bookkeeping.
   input wire logic [47:0] mac,
   output logic [3:0] n_words,
   output logic bad_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   logic [15:0] word;

   // Words one to three hold the address, low byte first.
   always_comb begin
      case (ee_req.addr)
         6'h01: word = mac[15:0];
         6'h02: word = mac[31:16];
         6'h03: word = mac[47:32];
         default: word = {10'h2b5, ee_req.addr};
      endcase
   end

   // Odd words answer two cycles late, even words at once.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ee_rsp <= '0;
         wait_cnt <= 2'h0;
         n_words <= 4'h0;
         bad_addr <= 1'b0;
      end else if (ee_req.req && !ee_rsp.valid &&
            wait_cnt == {ee_req.addr[0], 1'b0}) begin
         ee_rsp.valid <= 1'b1;
         ee_rsp.data <= word;
         wait_cnt <= 2'h0;
         n_words <= n_words + 4'h1;
         bad_addr <= bad_addr | (ee_req.addr > 6'h06);
      end else begin
         ee_rsp.valid <= 1'b0;
         ee_rsp.data <= ~ee_rsp.data;
         if (ee_req.req && !ee_rsp.valid) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the host register bank and start-up loader.
// Assumes the word reader model of hrm_ee_model on the loader side.
`default_nettype none
module tb_top import hrm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:1] CID = 15'h1357;  // Arbitrary value.
   localparam logic [15:0] PIDL = 16'h4c1e;  // Arbitrary value.
   localparam logic [15:0] PIDH = 16'h0e39;  // Arbitrary value.
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   logic cmd = 1'b0;
   logic [15:0] sd_in = 16'h0000;
   logic bus16_strap = 1'b1;
   logic ee_strap = 1'b1;
   logic [15:0] sd_out;
   logic sd_oe_n;
   logic ee_load_done;
   logic bus16_mode;
   logic bad_addr;
   hrm_ee_req_t ee_req;
   hrm_ee_rsp_t ee_rsp;
   logic [3:0] n_words;
   logic [47:0] mac;
   logic [15:0] q;
   logic [15:0] d;
   int seed = 32'h5a9a;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [10:0] resv [9] = '{11'h004, 11'h016, 11'h028, 11'h03a, 11'h058,
      11'h068, 11'h06e, 11'h082, 11'h0fe};
   logic [10:0] upper [6] = '{11'h100, 11'h16e, 11'h170, 11'h200,
      11'h5fe, 11'h7fe};

   always #20 clk_sys = ~clk_sys;

   hrm_regbank #(.CHIP_ID(CID), .PHY_ID_LOW(PIDL), .PHY_ID_HIGH(PIDH),
         .LOAD_WORDS(EE_WORDS)) uut (.clk_sys(clk_sys), .rst(rst),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cmd(cmd), .sd_in(sd_in),
      .sd_out(sd_out), .sd_oe_n(sd_oe_n), .bus16_strap(bus16_strap),
      .ee_strap(ee_strap), .ee_req(ee_req), .ee_rsp(ee_rsp),
      .ee_load_done(ee_load_done), .bus16_mode(bus16_mode));

   hrm_ee_model ee (.clk_sys(clk_sys), .rst(rst), .ee_req(ee_req),
      .ee_rsp(ee_rsp), .mac(mac), .n_words(n_words), .bad_addr(bad_addr));

   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] e,
         input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask

   // One strobe cycle: low for eight clocks, high for six.
   task automatic bus_op(input logic c, input logic [15:0] v,
         input logic rd, output logic [15:0] r);
      @(negedge clk_sys);
      cs_n = 1'b0;
      cmd = c;
      sd_in = v;
      rd_n = !rd;
      wr_n = rd;
      repeat (8) @(negedge clk_sys);
      r = sd_out;
      if (rd) check("drive enable", 16'h0000, {15'h0, sd_oe_n});
      rd_n = 1'b1;
      wr_n = 1'b1;
      sd_in = ~v;
      repeat (6) @(negedge clk_sys);
      cs_n = 1'b1;
   endtask

   // Command cycle with the address (two in 8-bit mode), then one data cycle.
   task automatic acc(input logic [10:0] a, input logic rd,
         input logic [15:0] v, output logic [15:0] r);
      logic [15:0] t;
      logic [3:0] en;
      en = a[1] ? 4'hc : 4'h3;
      if (bus16_strap) begin
         bus_op(1'b1, {en, 1'b0, a[10:2], 2'b00}, 1'b0, t);
      end else begin
         bus_op(1'b1, {8'h00, a[7:0]}, 1'b0, t);
         bus_op(1'b1, {13'h0, a[10:8]}, 1'b0, t);
      end
      bus_op(1'b0, v, rd, r);
   endtask

   // Reset value, then a random write read back through the mask.
   task automatic chk_reg(input logic [10:0] a, input logic [15:0] rv,
         input logic [15:0] m, input bit cr);
      logic [15:0] w;
      string n;
      n = $sformatf("reg %h", a);
      if (cr) begin
         acc(a, 1'b1, 16'($random(seed)), q);
         check(n, rv, q);
      end
      w = 16'($random(seed));
      acc(a, 1'b0, w, q);
      acc(a, 1'b1, 16'($random(seed)), q);
      check(n, (rv & ~m) | (w & m), q);
   endtask

   task automatic wait_done();
      int i;
      i = 0;
      while (ee_load_done !== 1'b1 && i < 200) begin
         @(negedge clk_sys);
         i++;
      end
      check("load done", 16'h0001, {15'h0, ee_load_done});
      repeat (8) @(negedge clk_sys);
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      mac = 48'({$random(seed), $random(seed)});
      repeat (5) @(negedge clk_sys);
      check("enable in reset", 16'h0001, {15'h0, sd_oe_n});
      rst = 1'b0;
      wait_done();
      check("bus width", 16'h0001, {15'h0, bus16_mode});
      check("words read", 16'h0007, {12'h0, n_words});
      check("word past six", 16'h0000, {15'h0, bad_addr});
      for (int i = 0; i < 3; i++) begin
         acc(OFF_HOSTMAC + 11'(2 * i), 1'b1, 16'h0000, q);
         check("host address", mac[16 * i +: 16], q);
      end
      chk_reg(OFF_CHIP_ID, {CID, 1'b0}, 16'h0001, 1'b1);
      chk_reg(OFF_GCTL1, 16'h3450, 16'hffff, 1'b1);
      chk_reg(OFF_GCTL7, 16'h0827, 16'hffff, 1'b1);
      chk_reg(OFF_STA1, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_STA2, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_STA3, 16'hffff, 16'hffff, 1'b1);
      chk_reg(OFF_IND1, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_IND4, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_IND5, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_INDCTL, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_PMCTL, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_POWER_EVENT_ENABLE, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_SLEEP, 16'h008e, 16'hffff, 1'b1);
      chk_reg(OFF_CTPD, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_PHYCTL, 16'h3120, 16'hffff, 1'b1);
      chk_reg(OFF_PHYSTS, 16'h7808, 16'h0000, 1'b1);
      chk_reg(OFF_PHYIDL, PIDL, 16'h0000, 1'b1);
      chk_reg(OFF_PHYIDH, PIDH, 16'h0000, 1'b1);
      chk_reg(OFF_ANADV, 16'h05e1, 16'hffff, 1'b1);
      chk_reg(OFF_ANLP, 16'h0001, 16'h0000, 1'b1);
      chk_reg(OFF_PHYSPC, 16'h0004, 16'hffff, 1'b1);
      chk_reg(OFF_PCTL1, 16'h0000, 16'hffff, 1'b1);
      chk_reg(OFF_DIAG, 16'h0400, 16'hffff, 1'b1);
      chk_reg(OFF_PCTL4, 16'h00ff, 16'hffff, 1'b1);
      chk_reg(OFF_PSTS, 16'h8000, 16'h0000, 1'b1);
      foreach (resv[i]) chk_reg(resv[i], 16'h0, 16'h0, 1'b1);
      foreach (upper[i]) chk_reg(upper[i], 16'h0, 16'hffff, 1'b0);
      bus_op(1'b1, 16'h30d0, 1'b0, q);
      bus_op(1'b1, 16'h0000, 1'b1, q);
      check("command readback", 16'h30d0, q);
      @(negedge clk_sys);
      rst = 1'b1;
      bus16_strap = 1'b0;
      ee_strap = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      wait_done();
      check("bus width", 16'h0000, {15'h0, bus16_mode});
      check("words read", 16'h0000, {12'h0, n_words});
      acc(OFF_GCTL7, 1'b1, 16'h0000, q);
      check("byte low", 16'h0027, {8'h00, q[7:0]});
      acc(OFF_GCTL7 + 11'h001, 1'b1, 16'h0000, q);
      check("byte high", 16'h0008, {8'h00, q[7:0]});
      d = 16'($random(seed));
      acc(OFF_SLEEP + 11'h001, 1'b0, d, q);
      acc(OFF_SLEEP, 1'b1, 16'h0000, q);
      check("byte low", 16'h008e, {8'h00, q[7:0]});
      acc(OFF_SLEEP + 11'h001, 1'b1, 16'h0000, q);
      check("byte high", {8'h00, d[7:0]}, {8'h00, q[7:0]});
      complete_run();
   end
endmodule
`default_nettype wire
